// File: logic/afp_pkg.sv
// package: constants and carrier types for the amplifier fault protection supervisor
package afp_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned POWERUP_MS = 10;
  localparam int unsigned DC_HOLD_MS = 420;
  localparam longint unsigned POWERUP_CYC = longint'(CLK_HZ) / 1000 * POWERUP_MS;
  localparam longint unsigned DC_HOLD_CYC = longint'(CLK_HZ) / 1000 * DC_HOLD_MS;

  // dc offset duty threshold in percent
  localparam int unsigned DC_DUTY_PCT = 60;
  // duty measurement window width in clock cycles
  localparam int unsigned DUTY_WIN_CYC = 100;
  localparam int unsigned DUTY_HI_CNT = DUTY_WIN_CYC * DC_DUTY_PCT / 100;

  // bit positions in the latched fault word
  localparam int unsigned FLT_OC = 0;
  localparam int unsigned FLT_OT = 1;
  localparam int unsigned FLT_DC = 2;
  localparam logic [2:0] FLT_NONE = 3'h0;

  // raw analog comparator outputs, asynchronous to ref_clk_i
  typedef struct packed {
    logic over_current;
    logic over_temp;
    logic supply_low;
    logic supply_high;
  } afp_sense_t;

  // differential pwm sign per channel: 1 means positive side dominant
  typedef struct packed {
    logic left_pos;
    logic right_pos;
  } afp_pwm_t;

endpackage

// File: logic/afp_dc_detect.sv
// file: per-channel dc offset detector on differential pwm polarity
`timescale 1ns/1ns
module afp_dc_detect #(
  parameter int unsigned WIN_CYC = 100,
  parameter int unsigned HI_CNT = 60,
  parameter longint unsigned HOLD_CYC = 21000000
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic pos_i,
  output logic fault_o
);
  localparam int WW = $clog2(WIN_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYC - 1);
  localparam logic [WW-1:0] HI_LIM = WW'(HI_CNT);
  localparam logic [HW-1:0] HOLD_LIM = HW'(HOLD_CYC);

  logic [WW-1:0] win_r, win_nxt, pcnt_r, pcnt_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  logic [1:0] pol_r, pol_nxt; // 2'b01 positive, 2'b10 negative, 0 none
  logic fault_nxt;
  logic [WW-1:0] pcnt_fin;
  logic [1:0] pol_now;

  // window duty measure, then hold counter on same polarity
  always_comb begin
    win_nxt = win_r + WW'(1);
    pcnt_nxt = pcnt_r + (pos_i ? WW'(1) : WW'(0));
    hold_nxt = hold_r;
    pol_nxt = pol_r;
    fault_nxt = 1'b0;
    pcnt_fin = pcnt_nxt;
    pol_now = 2'b00;
    if (pcnt_fin > HI_LIM) begin
      pol_now = 2'b01;
    end else if ((WW'(WIN_CYC) - pcnt_fin) > HI_LIM) begin
      pol_now = 2'b10;
    end
    if (!enable_i) begin
      win_nxt = '0;
      pcnt_nxt = '0;
      hold_nxt = '0;
      pol_nxt = 2'b00;
    end else if (win_r == WIN_LAST) begin
      win_nxt = '0;
      pcnt_nxt = '0;
      pol_nxt = pol_now;
      if (pol_now != 2'b00 && pol_now == pol_r) begin
        hold_nxt = (hold_r >= HOLD_LIM) ? hold_r : hold_r + HW'(WIN_CYC);
      end else begin
        hold_nxt = '0;
      end
    end
    fault_nxt = enable_i && (hold_nxt >= HOLD_LIM);
  end

  // registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      win_r <= '0;
      pcnt_r <= '0;
      hold_r <= '0;
      pol_r <= 2'b00;
      fault_o <= 1'b0;
    end else begin
      win_r <= win_nxt;
      pcnt_r <= pcnt_nxt;
      hold_r <= hold_nxt;
      pol_r <= pol_nxt;
      fault_o <= fault_nxt;
    end
  end

  AST_DC_NEEDS_ENABLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !enable_i |=> !fault_o)
    else $error("dc fault raised while detector disabled");

endmodule

// File: logic/afp_supervisor.sv
// file: top of the amplifier fault protection supervisor
`timescale 1ns/1ns
module afp_supervisor #(
  parameter longint unsigned POWERUP_CYC = afp_pkg::POWERUP_CYC,
  parameter longint unsigned DC_HOLD_CYC = afp_pkg::DC_HOLD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic shutdown_n_i,
  input wire afp_pkg::afp_sense_t sense_i,
  input wire afp_pkg::afp_pwm_t pwm_i,
  output logic protection_alarm_n_o,
  output logic protection_alarm_n_oe_o,
  output logic out_enable_o,
  output logic mute_o,
  output logic low_power_o,
  output logic [2:0] fault_latch_o
);
  localparam int PW = $clog2(POWERUP_CYC + 1);
  localparam logic [PW-1:0] PU_LAST = PW'(POWERUP_CYC - 1);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [4:0] s1_r, s2_r, s3_r;
  logic [4:0] raw_in;
  logic [4:0] stab_r, stab_nxt;
  assign raw_in = {shutdown_n_i, sense_i};

  // three-stage chains
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= 5'h10;
      s2_r <= 5'h10;
      s3_r <= 5'h10;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // take a new value only when stages two and three agree
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      stab_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stab_r[i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stab_r <= 5'h10;
    end else begin
      stab_r <= stab_nxt;
    end
  end

  logic sd_n, oc, ot, uv, ov;
  assign sd_n = stab_r[4];
  assign oc = stab_r[3];
  assign ot = stab_r[2];
  assign uv = stab_r[1];
  assign ov = stab_r[0];

  // ----------------------------------------
  // power-up sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {AFP_POWERUP, AFP_RUN} afp_state_t;
  afp_state_t state_r, state_nxt;
  logic [PW-1:0] pu_r, pu_nxt;

  // hold off amplification for the power-up interval
  always_comb begin
    state_nxt = state_r;
    pu_nxt = pu_r;
    case (state_r)
      AFP_POWERUP: begin
        pu_nxt = pu_r + PW'(1);
        if (pu_r == PU_LAST) begin
          state_nxt = AFP_RUN;
        end
      end
      AFP_RUN: begin
        pu_nxt = pu_r;
      end
      default: begin
        state_nxt = AFP_POWERUP;
        pu_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= AFP_POWERUP;
      pu_r <= '0;
    end else begin
      state_r <= state_nxt;
      pu_r <= pu_nxt;
    end
  end

  // ----------------------------------------
  // dc detect per channel
  // ----------------------------------------
  logic dc_l, dc_r;
  logic amp_active;
  assign amp_active = (state_r == AFP_RUN) && sd_n && !uv && !ov
                      && (fault_latch_o == afp_pkg::FLT_NONE);

  afp_dc_detect #(
    .WIN_CYC(afp_pkg::DUTY_WIN_CYC),
    .HI_CNT(afp_pkg::DUTY_HI_CNT),
    .HOLD_CYC(DC_HOLD_CYC)
  ) u_dc_left (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(amp_active),
    .pos_i(pwm_i.left_pos),
    .fault_o(dc_l)
  );

  afp_dc_detect #(
    .WIN_CYC(afp_pkg::DUTY_WIN_CYC),
    .HI_CNT(afp_pkg::DUTY_HI_CNT),
    .HOLD_CYC(DC_HOLD_CYC)
  ) u_dc_right (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(amp_active),
    .pos_i(pwm_i.right_pos),
    .fault_o(dc_r)
  );

  // ----------------------------------------
  // fault latches and outputs
  // ----------------------------------------
  logic [2:0] latch_nxt;
  logic sd_seen_low_r, sd_seen_low_nxt;
  logic clr;
  logic alarm_n_nxt, oe_nxt, mute_nxt, lowp_nxt;

  // clear once shutdown has stood low two cycles, so an alarm wired back to
  // shutdown can free itself; new events win over the clear
  always_comb begin
    sd_seen_low_nxt = sd_seen_low_r;
    if (!sd_n) begin
      sd_seen_low_nxt = 1'b1;
    end else begin
      sd_seen_low_nxt = 1'b0;
    end
    clr = sd_seen_low_r && !sd_n;
    latch_nxt = clr ? afp_pkg::FLT_NONE : fault_latch_o;
    if (oc && state_r == AFP_RUN) begin
      latch_nxt[afp_pkg::FLT_OC] = 1'b1;
    end
    if (ot && state_r == AFP_RUN) begin
      latch_nxt[afp_pkg::FLT_OT] = 1'b1;
    end
    if (dc_l || dc_r) begin
      latch_nxt[afp_pkg::FLT_DC] = 1'b1;
    end
    alarm_n_nxt = (latch_nxt == afp_pkg::FLT_NONE);
    oe_nxt = !alarm_n_nxt; // open drain: drive only while pulling low
    mute_nxt = !sd_n;
    lowp_nxt = !sd_n || state_r != AFP_RUN;
  end

  // supply faults float outputs without alarm and recover unaided
  logic en_nxt;
  assign en_nxt = (state_r == AFP_RUN) && sd_n && !uv && !ov
                  && (latch_nxt == afp_pkg::FLT_NONE);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sd_seen_low_r <= 1'b0;
      fault_latch_o <= 3'h0;
      protection_alarm_n_o <= 1'b1;
      protection_alarm_n_oe_o <= 1'b0;
      out_enable_o <= 1'b0;
      mute_o <= 1'b1;
      low_power_o <= 1'b1;
    end else begin
      sd_seen_low_r <= sd_seen_low_nxt;
      fault_latch_o <= latch_nxt;
      protection_alarm_n_o <= alarm_n_nxt;
      protection_alarm_n_oe_o <= oe_nxt;
      out_enable_o <= en_nxt;
      mute_o <= mute_nxt;
      low_power_o <= lowp_nxt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_OC_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (oc && state_r == AFP_RUN) |=> fault_latch_o[afp_pkg::FLT_OC] && !out_enable_o)
    else $error("over-current not latched");
  AST_OT_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ot && state_r == AFP_RUN) |=> !protection_alarm_n_o && !out_enable_o)
    else $error("over-temperature not reported");
  AST_DC_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (dc_l || dc_r) |=> fault_latch_o[afp_pkg::FLT_DC] && !protection_alarm_n_o)
    else $error("dc fault not latched");
  AST_UV_FLOAT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    uv |=> !out_enable_o)
    else $error("outputs active under low supply");
  AST_OV_FLOAT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ov && fault_latch_o == afp_pkg::FLT_NONE && !oc && !ot && !dc_l && !dc_r)
    |=> !out_enable_o && protection_alarm_n_o)
    else $error("supply fault misreported");
  // shutdown seen low on two cycles with no fault event pending
  sequence seq_sd_low_held;
    (!sd_n && !oc && !ot && !dc_l && !dc_r) [*2];
  endsequence
  AST_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    seq_sd_low_held |=> fault_latch_o == afp_pkg::FLT_NONE)
    else $error("latch not cleared while shutdown low");
  AST_POWERUP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r != AFP_RUN |=> !out_enable_o)
    else $error("amplifying during power-up");
  AST_MUTE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !sd_n |=> mute_o && low_power_o && !out_enable_o)
    else $error("not muted in shutdown");
  AST_ALARM: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    protection_alarm_n_o == (fault_latch_o == afp_pkg::FLT_NONE)
    && protection_alarm_n_oe_o == !protection_alarm_n_o)
    else $error("alarm does not follow latches");

endmodule

// File: test/afp_ctrl_model.sv
// system controller model: drives shutdown and watches the open-drain alarm
`timescale 1ns/1ns
module afp_ctrl_model (
  input wire logic alarm_n_i,
  input wire logic alarm_oe_i,
  input wire logic tie_i,
  input wire logic sd_req_n_i,
  output logic shutdown_n_o,
  output logic alarm_wire_o
);
  // ----------------------------------------
  // alarm wire and shutdown drive
  // ----------------------------------------
  // open-drain alarm line with a pull-up, high whenever nobody pulls it
  assign alarm_wire_o = alarm_oe_i ? alarm_n_i : 1'h1;
  // shutdown follows the bench request, or the alarm line wired back to it
  assign shutdown_n_o = tie_i ? alarm_wire_o : sd_req_n_i;
endmodule

// File: test/amp_fault_protection_supervisor_test.sv
// self-checking bench for the fault protection supervisor
`timescale 1ns/1ns
module amp_fault_protection_supervisor_test;
  // ----------------------------------------
  // signals and expected state
  // ----------------------------------------
  logic ref_clk = 1'h0, rst = 1'h1, tie = 1'h0, sd_req_n = 1'h0;
  logic dcl = 1'h0, dcr = 1'h0;
  logic [3:0] sense = 4'h0;
  logic [1:0] pwm = 2'h0;
  logic shutdown_n, alarm_n, alarm_oe, alarm_wire, out_en, mute, low_power;
  logic [2:0] latch;
  integer seed = 61778, error_cnt = 0, n_tests = 0, lat = 0, sup = 0, i;

  // clock at 50 MHz
  always #10 ref_clk = ~ref_clk;

  afp_supervisor #(.POWERUP_CYC(50), .DC_HOLD_CYC(300)) uut (
    .ref_clk_i(ref_clk), .rst_i(rst), .shutdown_n_i(shutdown_n), .sense_i(sense),
    .pwm_i(pwm), .protection_alarm_n_o(alarm_n), .protection_alarm_n_oe_o(alarm_oe),
    .out_enable_o(out_en), .mute_o(mute), .low_power_o(low_power), .fault_latch_o(latch));

  afp_ctrl_model ctrl (.alarm_n_i(alarm_n), .alarm_oe_i(alarm_oe), .tie_i(tie),
    .sd_req_n_i(sd_req_n), .shutdown_n_o(shutdown_n), .alarm_wire_o(alarm_wire));

  // pwm polarity: random near half duty, or one channel stuck for dc tests
  always @(negedge ref_clk) begin
    pwm <= (2'($random(seed)) | {dcl, 1'h0}) & {1'h1, !dcr};
  end

  // ----------------------------------------
  // helper tasks
  // ----------------------------------------
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask

  task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare every output except low_power against the expected latch and supply state
  task look;
    chk("fault_latch", lat[2:0], latch);
    chk("alarm_n", {2'h0, lat == 0}, {2'h0, alarm_n});
    chk("alarm_oe", {2'h0, lat != 0}, {2'h0, alarm_oe});
    chk("alarm_wire", {2'h0, lat == 0}, {2'h0, alarm_wire});
    chk("out_enable", {2'h0, lat == 0 && sup == 0}, {2'h0, out_en});
    chk("mute", 3'h0, {2'h0, mute});
  endtask

  // take shutdown low for a while, then release it; latches drop while it is low
  task clear;
    sd_req_n = 1'h0;
    cyc(8);
    lat = 0;
    chk("latch_sd", lat[2:0], latch);
    chk("alarm_n_sd", 3'h1, {2'h0, alarm_n});
    chk("mute_sd", 3'h1, {2'h0, mute});
    chk("low_power_sd", 3'h1, {2'h0, low_power});
    chk("out_enable_sd", 3'h0, {2'h0, out_en});
    sd_req_n = 1'h1;
    cyc(8);
    look;
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(10);
    rst = 1'h0;
    cyc(5);
    sd_req_n = 1'h1;
    cyc(25);
    chk("out_enable_pu", 3'h0, {2'h0, out_en});
    chk("low_power_pu", 3'h1, {2'h0, low_power});
    cyc(30);
    look;
    chk("low_power_run", 3'h0, {2'h0, low_power});
    clear;
    // latched faults: over-current then over-temperature
    for (i = 0; i < 2; i++) begin
      sense = (i == 0) ? 4'h8 : 4'h4;
      cyc(4 + ($unsigned($random(seed)) % 3));
      sense = 4'h0;
      cyc(8);
      lat = 1 << i;
      look;
      clear;
    end
    // supply under and over voltage recover by themselves
    for (i = 0; i < 2; i++) begin
      sense = (i == 0) ? 4'h2 : 4'h1;
      cyc(8);
      sup = 1;
      look;
      sense = 4'h0;
      cyc(8);
      sup = 0;
      look;
    end
    // dc offset on each channel, left positive then right negative
    for (i = 0; i < 2; i++) begin
      dcl = (i == 0);
      dcr = (i == 1);
      cyc(200);
      look;
      cyc(250);
      lat = 4;
      look;
      dcl = 1'h0;
      dcr = 1'h0;
      clear;
    end
    // set wins over a clear while the fault is still present
    sense = 4'h8;
    cyc(8);
    lat = 1;
    sd_req_n = 1'h0;
    cyc(6);
    sd_req_n = 1'h1;
    cyc(8);
    look;
    sense = 4'h0;
    clear;
    // alarm wired back to shutdown recovers on its own
    tie = 1'h1;
    sense = 4'h4;
    cyc(5);
    sense = 4'h0;
    cyc(30);
    lat = 0;
    look;
    final_report;
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    final_report;
  end
endmodule
